// file: hdl/sea_ctrl.sv
// serial eeprom access controller: registers, autoload and serial engine
`timescale 1ns/10ps
// Operation
// - start bit launches one eeprom access
// - command codes one through six, reset zero
// - autoload status one only after success
// - autoload disable bit, resets to one
// - serial clock is link clock over 64, over 8 at test rate
// - bit 8 reports write in progress
// - bit 9 reports write enable latch
// - bits 10, 11 block protection, writable
// - bit 15 write protect enable, writable
// - address field low half, reset zero
// - data field high half, reset zero
// - control at a0, address/data at a4
// - autoload replaces loadable default value
module sea_ctrl #(
  parameter logic [15:0] AL_SIG_ADDR = 16'h0000, // signature word address
  parameter logic [15:0] AL_CFG_ADDR = 16'h0001, // loadable word address
  parameter logic [15:0] AL_SIG = 16'h5a3c, // arbitrary signature value
  parameter logic [15:0] CFG_DEFAULT = 16'h0000 // loadable default
) (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // link clock
  input wire logic i_clk_core_link,
  // register port
  input wire sea_pkg::sea_bus_req_s i_bus,
  output logic [31:0] o_rd_data,
  // eeprom pins
  output sea_pkg::sea_ee_out_s o_ee,
  input wire logic i_ee_miso,
  // loadable value
  output logic [15:0] o_loaded_cfg
);
  import sea_pkg::*;

  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  if (AL_SIG_ADDR == AL_CFG_ADDR) begin : g_bad_addr
    $error("signature and load addresses must differ");
  end
  // incoming bit needs two sync flops plus one cycle before the rising edge
  if (SEA_HALF_TEST < 6'h02) begin : g_bad_div
    $error("test divider too fast for the data-in synchroniser");
  end

  // ----------------------------------------------------------------------
  // system side state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, // waiting
    ST_SW = 4'h2, // software access running
    ST_AL_SIG = 4'h4, // autoload reads signature
    ST_AL_CFG = 4'h8 // autoload reads loadable word
  } sea_st_e;

  typedef struct packed {
    sea_st_e st; // controller state
    logic start; // start bit
    logic [2:0] cmd; // command field
    logic al_ok; // autoload status
    logic al_dis; // autoload disable
    logic al_tried; // autoload attempted since reset
    logic [1:0] rate; // clock rate code
    logic [7:0] stat; // eeprom status byte
    logic [15:0] addr; // address field
    logic [15:0] data; // data field
    sea_op_s op; // operation handed to link side
    logic req_tgl; // request toggle
    logic ack_s1; // ack synchroniser stage 1
    logic ack_s2; // ack synchroniser stage 2
    logic ack_s3; // ack edge detect
    logic [31:0] rd_data; // read data
    logic [15:0] cfg; // loaded value
  } sea_sys_s;

  sea_sys_s sys_ff;
  sea_sys_s nxt_sys;

  // ----------------------------------------------------------------------
  // link side state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic req_s1; // request synchroniser stage 1
    logic req_s2; // request synchroniser stage 2
    logic req_s3; // request edge detect
    logic miso_s1; // data-in synchroniser stage 1
    logic miso_s2; // data-in synchroniser stage 2
    logic ack_tgl; // done toggle
    logic busy; // frame running
    sea_ee_out_s pins; // eeprom pins
    logic [5:0] div; // half period counter
    logic [5:0] half; // half period limit
    logic [5:0] left; // bits still to sample
    logic [39:0] tx; // outgoing bits
    logic [15:0] rx; // incoming bits
  } sea_lnk_s;

  sea_lnk_s lnk_ff;
  sea_lnk_s nxt_lnk;
  logic rst_l1_n; // link reset sync stage 1
  logic rst_l2_n; // link reset sync stage 2

  logic [15:0] rx_word; // link result seen by system side
  logic ack_evt; // link finished a frame
  logic wr_ctrl; // control register write
  logic wr_ad; // address/data register write

  assign rx_word = lnk_ff.rx;
  assign ack_evt = sys_ff.ack_s2 ^ sys_ff.ack_s3;
  assign wr_ctrl = i_bus.wr && (i_bus.addr == SEA_OFS_CTRL);
  assign wr_ad = i_bus.wr && (i_bus.addr == SEA_OFS_ADDR_DATA);

  // ----------------------------------------------------------------------
  // system side next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.ack_s1 = lnk_ff.ack_tgl;
    nxt_sys.ack_s2 = sys_ff.ack_s1;
    nxt_sys.ack_s3 = sys_ff.ack_s2;
    // register writes only land while idle, so the op stays stable
    if (sys_ff.st == ST_IDLE) begin
      if (wr_ctrl) begin
        nxt_sys.start = i_bus.wdata[SEA_CTRL_START];
        nxt_sys.cmd = i_bus.wdata[SEA_CTRL_CMD_LO +: 3];
        nxt_sys.al_dis = i_bus.wdata[SEA_CTRL_AL_DIS];
        nxt_sys.rate = i_bus.wdata[SEA_CTRL_RATE_LO +: 2];
        nxt_sys.stat[3:2] = i_bus.wdata[SEA_CTRL_STAT_LO + 2 +: 2];
        nxt_sys.stat[7] = i_bus.wdata[SEA_CTRL_STAT_LO + 7];
      end
      if (wr_ad) begin
        nxt_sys.addr = i_bus.wdata[SEA_ADDR_LO +: 16];
        nxt_sys.data = i_bus.wdata[SEA_DATA_LO +: 16];
      end
    end
    // register reads, data one cycle later
    nxt_sys.rd_data = 32'h0000_0000;
    if (i_bus.rd) begin
      if (i_bus.addr == SEA_OFS_CTRL) begin
        nxt_sys.rd_data = {16'h0000, sys_ff.stat, sys_ff.rate,
                           sys_ff.al_dis, sys_ff.al_ok, sys_ff.cmd,
                           sys_ff.start};
      end else if (i_bus.addr == SEA_OFS_ADDR_DATA) begin
        nxt_sys.rd_data = {sys_ff.data, sys_ff.addr};
      end
    end
    unique case (sys_ff.st)
      // waiting for work
      ST_IDLE: begin
        if (!sys_ff.al_tried && !sys_ff.al_dis) begin
          nxt_sys.al_tried = 1'h1;
          nxt_sys.op = '{cmd: SEA_CMD_READ, rate: sys_ff.rate,
                         addr: AL_SIG_ADDR, data: 16'h0000};
          nxt_sys.req_tgl = !sys_ff.req_tgl;
          nxt_sys.st = ST_AL_SIG;
        end else if (sys_ff.start) begin
          // hand the held command to the link side
          nxt_sys.op = '{cmd: sys_ff.cmd, rate: sys_ff.rate,
                         addr: sys_ff.addr,
                         data: (sys_ff.cmd == SEA_CMD_WR_STAT) ?
                               {8'h00, sys_ff.stat} : sys_ff.data};
          nxt_sys.req_tgl = !sys_ff.req_tgl;
          nxt_sys.st = ST_SW;
        end
      end
      // software access in flight
      ST_SW: begin
        if (ack_evt) begin
          nxt_sys.start = 1'h0;
          nxt_sys.st = ST_IDLE;
          if (sys_ff.op.cmd == SEA_CMD_READ) begin
            // read data lands with start clear
            nxt_sys.data = rx_word;
          end
          if (sys_ff.op.cmd == SEA_CMD_RD_STAT) begin
            // status byte copied, incl. busy and latch
            // write in progress from status bit 0
            // write enable latch from status bit 1
            nxt_sys.stat = rx_word[7:0];
          end
        end
      end
      // autoload signature check
      ST_AL_SIG: begin
        if (ack_evt) begin
          if (rx_word == AL_SIG) begin
            nxt_sys.op.addr = AL_CFG_ADDR;
            nxt_sys.req_tgl = !sys_ff.req_tgl;
            nxt_sys.st = ST_AL_CFG;
          end else begin
            nxt_sys.al_ok = 1'h0;
            nxt_sys.st = ST_IDLE;
          end
        end
      end
      // autoload fetch of the loadable word
      ST_AL_CFG: begin
        if (ack_evt) begin
          nxt_sys.cfg = rx_word;
          nxt_sys.al_ok = 1'h1;
          nxt_sys.st = ST_IDLE;
        end
      end
      default: begin
        nxt_sys.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // system side registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sys_ff <= '{st: ST_IDLE, start: 1'h0, cmd: SEA_RST_CMD,
                  al_ok: 1'h0, al_dis: SEA_RST_AL_DIS, al_tried: 1'h0,
                  rate: SEA_RST_RATE, stat: SEA_RST_STAT,
                  addr: SEA_RST_WORD, data: SEA_RST_WORD,
                  op: '0, req_tgl: 1'h0, ack_s1: 1'h0, ack_s2: 1'h0,
                  ack_s3: 1'h0, rd_data: 32'h0000_0000,
                  cfg: CFG_DEFAULT};
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  // ----------------------------------------------------------------------
  // link side reset synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_core_link) begin
    rst_l1_n <= i_rst_n;
    rst_l2_n <= rst_l1_n;
  end

  // ----------------------------------------------------------------------
  // link side next state: serial frame engine
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_lnk = lnk_ff;
    nxt_lnk.req_s1 = sys_ff.req_tgl;
    nxt_lnk.req_s2 = lnk_ff.req_s1;
    nxt_lnk.req_s3 = lnk_ff.req_s2;
    nxt_lnk.miso_s1 = i_ee_miso;
    nxt_lnk.miso_s2 = lnk_ff.miso_s1;
    if (!lnk_ff.busy) begin
      if (lnk_ff.req_s2 ^ lnk_ff.req_s3) begin
        // open a frame with the opcode first
        nxt_lnk.busy = 1'h1;
        nxt_lnk.pins.cs_n = 1'h0;
        nxt_lnk.pins.sck = 1'h0;
        nxt_lnk.div = 6'h00;
        // divide by 64, test mode faster
        nxt_lnk.half = (sys_ff.op.rate == SEA_RATE_TEST) ?
                       SEA_HALF_TEST : SEA_HALF_NORMAL;
        unique case (sys_ff.op.cmd)
          // address and data phases
          SEA_CMD_WRITE, SEA_CMD_READ: begin
            nxt_lnk.tx = {5'h00, sys_ff.op.cmd, sys_ff.op.addr,
                          sys_ff.op.data};
            nxt_lnk.left = SEA_BITS_LONG;
          end
          // one status byte
          SEA_CMD_WR_STAT, SEA_CMD_RD_STAT: begin
            nxt_lnk.tx = {5'h00, sys_ff.op.cmd, sys_ff.op.data[7:0],
                          24'h00_0000};
            nxt_lnk.left = SEA_BITS_STAT;
          end
          // opcode only
          default: begin
            nxt_lnk.tx = {5'h00, sys_ff.op.cmd, 32'h0000_0000};
            nxt_lnk.left = SEA_BITS_OP;
          end
        endcase
        nxt_lnk.pins.mosi = 1'h0;
      end
    end else if (lnk_ff.div == lnk_ff.half) begin
      nxt_lnk.div = 6'h00;
      if (!lnk_ff.pins.sck) begin
        // rising edge: sample incoming bit
        nxt_lnk.pins.sck = 1'h1;
        nxt_lnk.rx = {lnk_ff.rx[14:0], lnk_ff.miso_s2};
        nxt_lnk.left = lnk_ff.left - 6'h01;
      end else begin
        // falling edge: next bit out or close the frame
        nxt_lnk.pins.sck = 1'h0;
        if (lnk_ff.left == 6'h00) begin
          nxt_lnk.pins.cs_n = 1'h1;
          nxt_lnk.busy = 1'h0;
          // completion toggle back to system side
          nxt_lnk.ack_tgl = !lnk_ff.ack_tgl;
        end else begin
          nxt_lnk.tx = {lnk_ff.tx[38:0], 1'h0};
          nxt_lnk.pins.mosi = lnk_ff.tx[38];
        end
      end
    end else begin
      nxt_lnk.div = lnk_ff.div + 6'h01;
    end
    // first data bit must be valid before the first rising edge
    if (lnk_ff.busy && lnk_ff.pins.sck == 1'h0 && lnk_ff.left != 6'h00
        && lnk_ff.div == 6'h00) begin
      nxt_lnk.pins.mosi = lnk_ff.tx[39];
    end
  end

  // ----------------------------------------------------------------------
  // link side registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_core_link) begin
    if (!rst_l2_n) begin
      lnk_ff <= '{req_s1: 1'h0, req_s2: 1'h0, req_s3: 1'h0,
                  miso_s1: 1'h0, miso_s2: 1'h0, ack_tgl: 1'h0,
                  busy: 1'h0, pins: '{cs_n: 1'h1, sck: 1'h0, mosi: 1'h0},
                  div: 6'h00, half: 6'h00, left: 6'h00,
                  tx: 40'h00_0000_0000, rx: 16'h0000};
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------------
  assign o_rd_data = sys_ff.rd_data;
  assign o_ee = lnk_ff.pins;
  assign o_loaded_cfg = sys_ff.cfg;

endmodule : sea_ctrl

// file: hdl/sea_pkg.sv
// shared constants and carrier types of the serial eeprom access block
package sea_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] SEA_OFS_CTRL = 8'ha0; // eeprom_access_control
  localparam logic [7:0] SEA_OFS_ADDR_DATA = 8'ha4; // word address and data

  // ----------------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------------
  localparam int SEA_CTRL_START = 0; // start bit
  localparam int SEA_CTRL_CMD_LO = 1; // command field 3:1
  localparam int SEA_CTRL_AL_OK = 4; // autoload status
  localparam int SEA_CTRL_AL_DIS = 5; // autoload disable
  localparam int SEA_CTRL_RATE_LO = 6; // clock rate 7:6
  localparam int SEA_CTRL_STAT_LO = 8; // eeprom status byte 15:8
  localparam int SEA_ADDR_LO = 0; // address field 15:0
  localparam int SEA_DATA_LO = 16; // data field 31:16

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEA_RST_CMD = 3'h0;
  localparam logic SEA_RST_AL_DIS = 1'h1;
  localparam logic [1:0] SEA_RST_RATE = 2'h1;
  localparam logic [7:0] SEA_RST_STAT = 8'h00;
  localparam logic [15:0] SEA_RST_WORD = 16'h0000;

  // ----------------------------------------------------------------------
  // commands (also the serial opcodes) and clock rate codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEA_CMD_WR_STAT = 3'h1;
  localparam logic [2:0] SEA_CMD_WRITE = 3'h2;
  localparam logic [2:0] SEA_CMD_READ = 3'h3;
  localparam logic [2:0] SEA_CMD_WR_DIS = 3'h4;
  localparam logic [2:0] SEA_CMD_RD_STAT = 3'h5;
  localparam logic [2:0] SEA_CMD_WR_EN = 3'h6;
  localparam logic [1:0] SEA_RATE_TEST = 2'h3;

  // ----------------------------------------------------------------------
  // timing counts in link clock cycles, frame lengths in bits
  // ----------------------------------------------------------------------
  localparam int SEA_DIV_NORMAL = 64; // serial clock = link clock / 64
  // test mode divider; a half period of at least three link clocks leaves
  // the two-flop data-in synchroniser time to settle before sampling
  localparam int SEA_DIV_TEST = 8;
  localparam logic [5:0] SEA_HALF_NORMAL = 6'(SEA_DIV_NORMAL / 2 - 1);
  localparam logic [5:0] SEA_HALF_TEST = 6'(SEA_DIV_TEST / 2 - 1);
  localparam logic [5:0] SEA_BITS_LONG = 6'h28; // opcode+address+data
  localparam logic [5:0] SEA_BITS_STAT = 6'h10; // opcode+status byte
  localparam logic [5:0] SEA_BITS_OP = 6'h08; // opcode only

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr; // byte address
    logic [31:0] wdata; // write data
    logic wr; // write strobe
    logic rd; // read strobe
  } sea_bus_req_s;

  typedef struct packed {
    logic cs_n; // chip select, active low
    logic sck; // serial clock
    logic mosi; // serial data to eeprom
  } sea_ee_out_s;

  typedef struct packed {
    logic [2:0] cmd; // command / opcode
    logic [1:0] rate; // clock rate code
    logic [15:0] addr; // eeprom address
    logic [15:0] data; // write data or status byte
  } sea_op_s;

endpackage : sea_pkg

// file: tb/sea_ctrl_checker.sv
// port checker of the serial eeprom access block
`timescale 1ns/10ps
module sea_ctrl_checker
  import sea_pkg::*;
(
  // clocks and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_core_link,
  // register port
  input wire sea_pkg::sea_bus_req_s i_bus,
  input wire logic [31:0] o_rd_data,
  // eeprom pins and loaded value
  input wire sea_pkg::sea_ee_out_s o_ee,
  input wire logic i_ee_miso,
  input wire logic [15:0] o_loaded_cfg
);
  // ------------------------------------------------------------------
  // helper: rising serial clock edges inside the current frame
  // ------------------------------------------------------------------
  logic sck_q_ff; // serial clock one link cycle back
  logic [5:0] nbits_ff; // bits clocked so far
  // counter clears while deselected
  always_ff @(posedge i_clk_core_link) begin
    sck_q_ff <= o_ee.sck;
    if (o_ee.cs_n) begin
      nbits_ff <= 6'h00;
    end else if (o_ee.sck && !sck_q_ff) begin
      nbits_ff <= nbits_ff + 6'h01;
    end
  end
  // ------------------------------------------------------------------
  // frame edges and assertions
  // ------------------------------------------------------------------
  sequence s_open;
    $fell(o_ee.cs_n);
  endsequence
  sequence s_close;
    $rose(o_ee.cs_n);
  endsequence
  a_rd_data_idle: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n) !$past(i_bus.rd) |-> o_rd_data == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n) i_bus.rd && i_bus.addr != SEA_OFS_CTRL &&
    i_bus.addr != SEA_OFS_ADDR_DATA |=> o_rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_sck_idle_low: assert property (@(posedge i_clk_core_link)
    disable iff (!i_rst_n) o_ee.cs_n |-> !o_ee.sck)
    else $error("serial clock high while idle");
  a_half_period: assert property (@(posedge i_clk_core_link)
    disable iff (!i_rst_n) $changed(o_ee.sck) |=> $stable(o_ee.sck))
    else $error("serial clock half period too short");
  a_mosi_setup: assert property (@(posedge i_clk_core_link)
    disable iff (!i_rst_n)
    $rose(o_ee.sck) |-> $stable(o_ee.mosi) ##1 $stable(o_ee.mosi))
    else $error("data moved around rising serial clock");
  a_frame_start: assert property (@(posedge i_clk_core_link)
    disable iff (!i_rst_n) s_open |-> !o_ee.sck ##1 !o_ee.sck)
    else $error("frame opened without clock low lead");
  a_frame_len: assert property (@(posedge i_clk_core_link)
    disable iff (!i_rst_n) s_close |-> nbits_ff inside {6'h08, 6'h10, 6'h28})
    else $error("frame length wrong");
  a_opcode_msb: assert property (@(posedge i_clk_core_link)
    disable iff (!i_rst_n) $rose(o_ee.sck) && nbits_ff < 6'h05 |-> !o_ee.mosi)
    else $error("opcode upper bits not zero");
endmodule : sea_ctrl_checker

bind sea_ctrl sea_ctrl_checker u_chk (
  .i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n),
  .i_clk_core_link(i_clk_core_link),
  .i_bus(i_bus),
  .o_rd_data(o_rd_data),
  .o_ee(o_ee),
  .i_ee_miso(i_ee_miso),
  .o_loaded_cfg(o_loaded_cfg)
);

// file: tb/sea_ee_model.sv
// behavioural serial configuration eeprom, mode 0
`timescale 1ns/10ps
module sea_ee_model (
  // serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso
);
  logic [15:0] mem [16]; // word store
  logic [7:0] st; // status: wpen, bp1, bp0, wel, wip
  logic [39:0] sh; // shifted-in bits
  logic [2:0] op; // opcode of the frame
  logic [15:0] dout; // outgoing word
  int n; // bits taken this frame
  // signature word and loadable word
  initial begin
    foreach (mem[k]) mem[k] = 16'h0000;
    mem[0] = 16'h5a3c;
    mem[1] = 16'hc3e1;
    st = 8'h00;
    op = 3'h0;
    o_miso = 1'b0;
  end
  // new frame
  always @(negedge i_cs_n) n = 0;
  // take data on rising clock, latch opcode and reply
  always @(posedge i_sck) if (!i_cs_n) begin
    sh = {sh[38:0], i_mosi};
    n = n + 1;
    if (n == 8) op = sh[2:0];
    if (n == 8 && op == 3'h5) dout = {st, 8'h00};
    if (n == 24 && op == 3'h3) dout = mem[sh[3:0]];
  end
  // reply on falling clock; otherwise the line wanders
  always @(negedge i_sck) if (!i_cs_n) begin
    if ((op == 3'h3 && n >= 24 && n < 40) || (op == 3'h5 && n < 16)) begin
      o_miso = dout[15];
      dout = {dout[14:0], 1'b0};
    end else begin
      o_miso = ~o_miso;
    end
  end
  // commit at deselect; writes need the enable latch
  always @(posedge i_cs_n) begin
    o_miso = ~o_miso;
    if (st[1] && op == 3'h2 && n == 40) begin
      mem[sh[19:16]] = sh[15:0];
      st[1] = 1'b0;
    end else if (st[1] && op == 3'h1 && n == 16) begin
      st = {sh[7], 3'h0, sh[3:2], 2'h0};
    end
    if (op == 3'h6 && n == 8) st[1] = 1'b1;
    if (op == 3'h4 && n == 8) st[1] = 1'b0;
  end
endmodule : sea_ee_model

// file: tb/tb.sv
// self-checking bench of the serial eeprom access block
`timescale 1ns/10ps
module tb;
  import sea_pkg::*;
  // ------------------------------------------------------------------
  // clocks, bus and pins
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  sea_bus_req_s bus = '0;
  logic [31:0] rd_data;
  sea_ee_out_s ee;
  logic miso;
  logic [15:0] cfg;
  int failures = 0;
  int comparisons = 0;
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  // 160 ns link clock, offset phase
  initial begin
    #13;
    forever #80 lclk = ~lclk;
  end
  sea_ctrl dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_core_link(lclk),
    .i_bus(bus), .o_rd_data(rd_data), .o_ee(ee), .i_ee_miso(miso),
    .o_loaded_cfg(cfg));
  sea_ee_model u_ee (.i_cs_n(ee.cs_n), .i_sck(ee.sck), .i_mosi(ee.mosi),
    .o_miso(miso));
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : bus_wr
  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask : bus_rd
  // poll the control register until start clears, bounded
  task automatic poll();
    logic [31:0] v;
    int i;
    for (i = 0; i < 20000; i++) begin
      bus_rd(SEA_OFS_CTRL, v);
      if (v[0] === 1'b0) break;
    end
    if (i == 20000) begin
      failures++;
      final_report();
    end
  endtask : poll
  // launch a command at test rate and wait for completion
  task automatic go(input logic [2:0] c, input logic [7:0] hi);
    bus_wr(SEA_OFS_CTRL, {16'h0, hi, 2'b11, 2'b00, c, 1'b1});
    poll();
  endtask : go
  task automatic stat(input logic [7:0] e);
    logic [31:0] v;
    bus_rd(SEA_OFS_CTRL, v);
    chk({24'h0, v[15:8]}, {24'h0, e});
  endtask : stat
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] v;
    bus_rd(SEA_OFS_CTRL, v);
    chk(v, 32'h0000_0060);
    bus_rd(SEA_OFS_ADDR_DATA, v);
    chk(v, 32'h0000_0000);
    bus_wr(SEA_OFS_ADDR_DATA, 32'hbeef_0002);
    bus_rd(SEA_OFS_ADDR_DATA, v);
    chk(v, 32'hbeef_0002);
    bus_wr(SEA_OFS_CTRL, 32'h0000_ff60);
    bus_rd(SEA_OFS_CTRL, v);
    chk(v, 32'h0000_8c60);
    bus_wr(8'ha8, 32'hffff_ffff);
    bus_rd(8'ha8, v);
    chk(v, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_autoload();
    logic [31:0] v;
    int i;
    bus_wr(SEA_OFS_CTRL, 32'h0000_00c0);
    for (i = 0; i < 30000 && cfg !== 16'hc3e1; i++) @(posedge clk);
    if (i == 30000) begin
      failures++;
      final_report();
    end
    chk({16'h0, cfg}, 32'h0000_c3e1);
    bus_rd(SEA_OFS_CTRL, v);
    chk(v, 32'h0000_00d0);
    $display("test autoload done");
  endtask : t_autoload
  task automatic t_data();
    logic [31:0] v;
    go(SEA_CMD_WR_EN, 8'h00);
    go(SEA_CMD_RD_STAT, 8'h00);
    stat(8'h02);
    bus_wr(SEA_OFS_ADDR_DATA, 32'ha5c3_0003);
    go(SEA_CMD_WRITE, 8'h00);
    bus_wr(SEA_OFS_ADDR_DATA, 32'h0000_0003);
    go(SEA_CMD_READ, 8'h00);
    bus_rd(SEA_OFS_ADDR_DATA, v);
    chk(v, 32'ha5c3_0003);
    $display("test data done");
  endtask : t_data
  task automatic t_status();
    go(SEA_CMD_WR_EN, 8'h00);
    go(SEA_CMD_WR_STAT, 8'h8c);
    go(SEA_CMD_RD_STAT, 8'h00);
    stat(8'h8c);
    go(SEA_CMD_WR_EN, 8'h8c);
    go(SEA_CMD_WR_DIS, 8'h8c);
    go(SEA_CMD_RD_STAT, 8'h00);
    stat(8'h8c);
    $display("test status done");
  endtask : t_status
  // normal rate: serial clock stays high for half of 64 link clocks
  task automatic t_rate();
    int i;
    int n;
    bus_wr(SEA_OFS_CTRL, {24'h0, 2'b01, 2'b00, SEA_CMD_WR_DIS, 1'b1});
    for (i = 0; i < 400 && ee.sck !== 1'b1; i++) @(negedge lclk);
    for (n = 0; n < 400 && ee.sck === 1'b1; n++) @(negedge lclk);
    if (i == 400) begin
      failures++;
      final_report();
    end
    chk(n, SEA_DIV_NORMAL / 2);
    poll();
    $display("test rate done");
  endtask : t_rate
  // reset long enough for the link side, then run
  initial begin
    repeat (16) @(posedge lclk);
    @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_autoload();
    t_data();
    t_status();
    t_rate();
    final_report();
  end
endmodule : tb
